// ===== hw/vscore_adc.sv
/*
 * Behavioural sample source: one conversion of a channel.
 * Assumes start pulses only while idle; held cleared by reset or low run.
 */
`timescale 1ns/10ps
module vscore_adc #(
    parameter int CYCLES = 80
) (
    // Clock and control
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       run,
    // Request
    input  wire logic       start,
    input  wire logic [3:0] channel,
    // Result
    output logic            done,
    output logic [5:0]      code
);
    logic [$clog2(CYCLES+1)-1:0] cnt_q;
    logic                        busy_q;
    logic [3:0]                  ch_q;

    // A conversion needs a start cycle and a done cycle at least
    if (CYCLES < 2) begin : g_bad_cycles
        $error("vscore_adc: CYCLES must be at least 2");
    end

    // Conversion timer; internal clock gated off outside run
    always_ff @(posedge clk) begin
        if (srst || !run) begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
            ch_q   <= 4'h0;
            done   <= 1'b0;
            code   <= 6'h00;
        end else if (ce) begin
            done <= 1'b0;
            if (start && !busy_q) begin
                busy_q <= 1'b1;
                ch_q   <= channel;
                cnt_q  <= ($clog2(CYCLES+1))'(CYCLES - 1);
            end else if (busy_q) begin
                if (cnt_q == '0) begin
                    busy_q <= 1'b0;
                    done   <= 1'b1;
                    code   <= {ch_q, 2'h0} ^ 6'h2a; // Deterministic stand-in code
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule

// ===== hw/vscore_pkg.sv
/*
 * Shared constants for the voltage sensor core-access block.
 * Assumes a single 40 MHz clock domain and synchronous active-high reset.
 */
package vscore_pkg;
    localparam int          CFG_W          = 8;
    localparam int          CHSEL_W        = 4;
    localparam int          DATA_W         = 12;
    localparam int          SAMPLE_W       = 6;
    // Configuration word field positions and reset value
    localparam int          CFG_MODE_LSB   = 0;
    localparam int          CFG_CAL_BIT    = 6;
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    // Sequencer mode encodings
    localparam logic [1:0]  MODE_CH2_TO_7  = 2'h0;
    localparam logic [1:0]  MODE_CH0_TO_7  = 2'h1;
    localparam logic [1:0]  MODE_CH0_TO_1  = 2'h2;
    localparam logic [1:0]  MODE_DIRECTED  = 2'h3;
    // Conversion time per channel in ns (2 us at 500 ksps)
    localparam int          CONV_TIME_NS   = 2000;
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          CONV_CYCLES    = CONV_TIME_NS / CLK_PERIOD_NS;
    // Calibration adds a fixed offset to the converted code
    localparam logic [5:0]  CAL_OFFSET     = 6'h00;
endpackage

// ===== hw/vscore_top.sv
/*
 * Voltage sensor core-access logic: serial configuration, channel
 * sequencing, per-channel and per-sequence completion and sample output.
 * Assumes fabric logic sequences access enable, reset and configuration.
 * Directed mode treats every channel as a one-channel sequence, so each
 * result there carries the sequence-done flag as well.
 */
// Contract
// - Falling shift strobe starts conversion with the newly loaded configuration.
// - Non-directed modes convert the implied channels in turn, flagging each done.
// - Last channel of a sequence raises conversion-done and sequence-done together.
// - Sequence restarts automatically until enable low or reset high.
// - Directed mode: strobe fall starts conversion of the selected channel.
// - Mode 00 channels 2-7, 01 channels 0-7, 10 channels 0-1, 11 select.
// - Configuration word shifts in least significant bit first.
// - Sequence-done pulses for exactly one clock after a full sequence.
// - Reset high clears all registers and gates the conversion clock off.
`timescale 1ns/10ps
module vscore_top
    import vscore_pkg::*;
#(
    parameter int CONV_CYC = vscore_pkg::CONV_CYCLES
) (
    // Clock, reset, enable
    input  wire logic                         CLOCK,
    input  wire logic                         SRST,
    input  wire logic                         CE,
    // Sensor control from fabric
    input  wire logic                         SENSOR_RESET,
    input  wire logic                         CORE_ACCESS_ENABLE_ALT,
    input  wire logic                         CFG_SHIFT,
    input  wire logic                         CFG_DATA,
    input  wire logic [vscore_pkg::CHSEL_W-1:0] CHANNEL_SELECT,
    // Results to fabric
    output logic                              CONV_DONE,
    output logic                              SEQ_DONE,
    output logic [vscore_pkg::DATA_W-1:0]     DATA_OUT
);
    import vscore_pkg::*;

    typedef enum logic [1:0] {VS_IDLE, VS_START, VS_CONVERT} vscore_state_e;

    vscore_state_e    state_q;
    logic [7:0]       cfg_shreg_q;
    logic [7:0]       cfg_q;
    logic             shift_q;
    logic [3:0]       ch_q;
    logic             last_q;
    logic             run;
    logic             adc_start;
    logic             adc_done;
    logic [5:0]       adc_code;
    logic             strobe_fell;
    logic [1:0]       new_mode;
    logic [1:0]       cur_mode;
    logic [3:0]       next_ch;
    logic             next_last;
    logic [5:0]       cal_sample;

    // Elaboration checks: the converter needs a start and a done cycle, and
    // the port widths are tied to the fixed configuration and sample layout
    if (CONV_CYC < 2) begin : g_bad_conv
        $error("vscore_top: CONV_CYC must be at least 2");
    end
    if (CHSEL_W != 4) begin : g_bad_chsel
        $error("vscore_top: channel select must be 4 bits wide");
    end
    if (DATA_W != 2 * SAMPLE_W) begin : g_bad_data
        $error("vscore_top: data word must hold the sample and a reserved half");
    end
    if (CFG_W != 8) begin : g_bad_cfg
        $error("vscore_top: configuration word must be 8 bits wide");
    end

    // First channel of the sequence picked by the mode field
    function automatic logic [3:0] first_ch(input logic [1:0] mode, input logic [3:0] sel);
        case (mode)
            MODE_CH2_TO_7: first_ch = 4'h2;
            MODE_CH0_TO_7: first_ch = 4'h0;
            MODE_CH0_TO_1: first_ch = 4'h0;
            default:       first_ch = sel;
        endcase
    endfunction

    // Last channel of the sequence picked by the mode field
    function automatic logic [3:0] last_ch(input logic [1:0] mode, input logic [3:0] sel);
        case (mode)
            MODE_CH2_TO_7: last_ch = 4'h7;
            MODE_CH0_TO_7: last_ch = 4'h7;
            MODE_CH0_TO_1: last_ch = 4'h1;
            default:       last_ch = sel;
        endcase
    endfunction

    // Sequencer mode field of a configuration word
    function automatic logic [1:0] mode_of(input logic [7:0] cfg);
        mode_of = cfg[CFG_MODE_LSB +: 2];
    endfunction

    // Sensor runs only with core access on and its reset low
    assign run = CORE_ACCESS_ENABLE_ALT && !SENSOR_RESET;
    assign adc_start = (state_q == VS_START);

    // Strobe fall, seen at the first edge with the strobe low after a high
    assign strobe_fell = shift_q && !CFG_SHIFT;

    // Mode about to be loaded, and mode of the running sequence
    assign new_mode = mode_of(cfg_shreg_q);
    assign cur_mode = mode_of(cfg_q);

    // Calibrated sample; the sum is kept to the six sample bits on purpose
    assign cal_sample = 6'(adc_code + (cfg_q[CFG_CAL_BIT] ? CAL_OFFSET : 6'h00));

    // Channel and last flag that follow the current one in a running sequence.
    // Directed mode takes whatever the select input shows at the done edge, so
    // the fabric must have it settled a cycle before the done pulse.
    always_comb begin
        next_ch   = ch_q + 4'h1;
        next_last = (ch_q + 4'h1) == last_ch(cur_mode, 4'h0);
        if (cur_mode == MODE_DIRECTED) begin
            next_ch   = CHANNEL_SELECT;
            next_last = 1'b1;
        end else if (last_q) begin
            // End of a pass: wrap to the first channel of the same mode
            next_ch   = first_ch(cur_mode, 4'h0);
            next_last = first_ch(cur_mode, 4'h0) == last_ch(cur_mode, 4'h0);
        end
    end

    // Serial configuration shift, LSB first, loaded on strobe fall
    always_ff @(posedge CLOCK) begin
        if (SRST || SENSOR_RESET) begin
            cfg_shreg_q <= CFG_RESET;
            cfg_q       <= CFG_RESET;
            shift_q     <= 1'b0;
        end else if (CE) begin
            shift_q <= CFG_SHIFT;
            if (CFG_SHIFT) begin
                cfg_shreg_q <= {CFG_DATA, cfg_shreg_q[7:1]};
            end
            if (shift_q && !CFG_SHIFT) begin
                cfg_q <= cfg_shreg_q;
            end
        end
    end

    // Channel sequencer. Timing from the edge that sees the strobe low:
    // that edge loads START, the next edge starts the converter, CONV_CYC
    // edges later the converter reports done, and the edge after that
    // raises CONV_DONE. Each further channel follows CONV_CYC + 2 cycles on.
    // A strobe fall in mid-sequence wins over the running conversion, so the
    // fabric must only reconfigure after a sequence-done cycle.
    always_ff @(posedge CLOCK) begin
        if (SRST || SENSOR_RESET || !CORE_ACCESS_ENABLE_ALT) begin
            state_q <= VS_IDLE;
            ch_q    <= 4'h0;
            last_q  <= 1'b0;
        end else if (CE) begin
            if (strobe_fell) begin
                // Strobe fall restarts with the new configuration
                state_q <= VS_START;
                ch_q    <= first_ch(new_mode, CHANNEL_SELECT);
                last_q  <= (new_mode == MODE_DIRECTED) ||
                           (first_ch(new_mode, CHANNEL_SELECT) ==
                            last_ch(new_mode, CHANNEL_SELECT));
            end else begin
                case (state_q)
                    // Waits for a strobe fall
                    VS_IDLE: state_q <= VS_IDLE;
                    // Start pulse to the converter lasts this one cycle
                    VS_START: state_q <= VS_CONVERT;
                    // On done, step to the next channel and convert again
                    VS_CONVERT: begin
                        if (adc_done) begin
                            state_q <= VS_START;
                            ch_q    <= next_ch;
                            last_q  <= next_last;
                        end
                    end
                    default: state_q <= VS_IDLE;
                endcase
            end
        end
    end

    // Completion flags and sample output
    always_ff @(posedge CLOCK) begin
        if (SRST || SENSOR_RESET) begin
            CONV_DONE <= 1'b0;
            SEQ_DONE  <= 1'b0;
            DATA_OUT  <= '0;
        end else if (CE) begin
            CONV_DONE <= adc_done;
            SEQ_DONE  <= adc_done && last_q;
            if (adc_done) begin
                DATA_OUT <= {cal_sample, 6'h00};
            end
        end
    end

    // One-channel converter
    vscore_adc #(
        .CYCLES (CONV_CYC)
    ) u_adc (
        .clk     (CLOCK),
        .srst    (SRST),
        .ce      (CE),
        .run     (run),
        .start   (adc_start),
        .channel (ch_q),
        .done    (adc_done),
        .code    (adc_code)
    );
endmodule

// ===== testbench/tb_vscore_top.sv
/* Self-checking bench for vscore_top.
   Assumes vscore_ctl as the fabric side; checker bound separately. */
`timescale 1ns/10ps
module tb_vscore_top;
    import vscore_pkg::*;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        en, rs, sh, dt, cd, sd, cal;
    logic [3:0]  ch;
    logic [11:0] dout;
    logic [12:0] n;
    logic [12:0] q[$];
    logic [7:0]  lf = 8'h2a;
    int          mismatches = 0;
    int          compares = 0;
    // 40 MHz clock
    always #12.5 clock = ~clock;
    vscore_top #(.CONV_CYC(4)) u_dut (.CLOCK(clock), .SRST(srst), .CE(1'b1),
        .SENSOR_RESET(rs), .CORE_ACCESS_ENABLE_ALT(en), .CFG_SHIFT(sh), .CFG_DATA(dt),
        .CHANNEL_SELECT(ch), .CONV_DONE(cd), .SEQ_DONE(sd), .DATA_OUT(dout));
    vscore_ctl u_ctl (.clk(clock), .en(en), .rst(rs), .shift(sh), .dat(dt), .chsel(ch));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [11:0] expd(input logic [3:0] c);
        return {({c, 2'b00} ^ 6'h2a) + (cal ? CAL_OFFSET : 6'h00), 6'h00};
    endfunction
    task automatic check(input logic [11:0] e, input logic es);
        compares++;
        if (dout !== e || sd !== es) begin
            mismatches++;
            $display("mismatch at %0t: data %h end %b", $time, dout, sd);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Sequencer modes: two passes each, so the restart is seen
    task automatic run_mode(input logic [1:0] md);
        logic [3:0] lo;
        logic [3:0] hi;
        lf = lfsr(lf);
        cal = lf[0];
        lo = (md == MODE_CH2_TO_7) ? 4'h2 : 4'h0;
        hi = (md == MODE_CH0_TO_1) ? 4'h1 : 4'h7;
        for (int p = 0; p < 2; p++) begin
            for (logic [3:0] c = lo; c <= hi; c++) q.push_back({c == hi, expd(c)});
        end
        u_ctl.start({1'b0, cal, 4'h0, md}, 4'h0);
        while (q.size() != 0) @(posedge clock);
        @(negedge clock) u_ctl.stop();
        $display("mode %0d test done", md);
    endtask
    // Directed mode: next channel set right after each result
    task automatic run_dir;
        logic [3:0] c;
        cal = 1'b1;
        c = 4'h5;
        q.push_back({1'b1, expd(c)});
        u_ctl.start(8'h43, c);
        for (int k = 0; k < 6; k++) begin
            lf = lfsr(lf);
            c = {1'b0, lf[2:0]};
            @(negedge clock) u_ctl.chsel = c;
            q.push_back({1'b1, expd(c)});
            @(negedge clock iff cd === 1'b1);
        end
        while (q.size() != 0) @(posedge clock);
        @(negedge clock) u_ctl.stop();
        $display("directed test done");
    endtask
    // Compare each result with the oldest expectation
    always @(negedge clock) begin
        if (cd === 1'b1) begin
            if (q.size() == 0) begin
                mismatches++;
                $display("mismatch at %0t: unexpected result", $time);
            end else begin
                n = q.pop_front();
                check(n[11:0], n[12]);
            end
        end
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock) srst = 1'b0;
        for (int m = 0; m < 3; m++) run_mode(m[1:0]);
        run_dir();
        finish_test();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        finish_test();
    end
endmodule

// ===== testbench/vscore_ctl.sv
/* Fabric controller model: access enable, reset release, serial config.
   Assumes the bench calls its tasks; drives on the falling clock edge. */
`timescale 1ns/10ps
module vscore_ctl (
    // Clock and sensor control
    input  wire logic  clk,
    output logic       en = 1'b0,
    output logic       rst = 1'b1,
    output logic       shift = 1'b0,
    output logic       dat = 1'b0,
    output logic [3:0] chsel = 4'h0
);
    // Open access, release reset, shift the word and start conversion
    task automatic start(input logic [7:0] cfg, input logic [3:0] ch);
        @(negedge clk) en = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chsel = ch;
        for (int i = 0; i < 8; i++) begin
            shift = 1'b1;
            dat = cfg[i];
            @(negedge clk);
        end
        shift = 1'b0;
        dat = ~dat;
    endtask
    // Stop the sensor so that the next start is a fresh sequence
    task automatic stop;
        en = 1'b0;
        rst = 1'b1;
    endtask
endmodule

// ===== testbench/vscore_top_props.sv
/* Port assertions for vscore_top.
   Assumes one clock, CE held high, synchronous active-high resets. */
`timescale 1ns/10ps
module vscore_top_props
    import vscore_pkg::*;
#(
    parameter int CONV_CYC = 80
) (
    // Clock and resets
    input wire logic              CLOCK,
    input wire logic              SRST,
    input wire logic              SENSOR_RESET,
    // Configuration strobe
    input wire logic              CFG_SHIFT,
    input wire logic              CFG_DATA,
    // Results
    input wire logic              CONV_DONE,
    input wire logic              SEQ_DONE,
    input wire logic [DATA_W-1:0] DATA_OUT
);
    localparam int PER  = CONV_CYC + 2;
    localparam int PER1 = CONV_CYC + 3;
    logic [7:0] cfg_q;
    // Shadow of the configuration word, first bit ends up at bit 0
    always_ff @(posedge CLOCK) begin
        if (SRST) cfg_q <= 8'h00;
        else if (CFG_SHIFT) cfg_q <= {CFG_DATA, cfg_q[7:1]};
    end
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (SRST || SENSOR_RESET);
    property p_pair; SEQ_DONE |-> CONV_DONE; endproperty
    a_pair: assert property (p_pair) else $error("sequence end without conversion end");
    property p_seq_one; SEQ_DONE |=> !SEQ_DONE; endproperty
    a_seq_one: assert property (p_seq_one) else $error("sequence end longer than one cycle");
    property p_hold; !CONV_DONE |-> $stable(DATA_OUT); endproperty
    a_hold: assert property (p_hold) else $error("sample changed without a result");
    property p_rst; disable iff (SRST) SENSOR_RESET |=> !CONV_DONE && DATA_OUT == '0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
    property p_start; $fell(CFG_SHIFT) |-> ##[PER:PER1] CONV_DONE; endproperty
    a_start: assert property (p_start) else $error("no result after strobe fall");
    property p_period; CONV_DONE && !SEQ_DONE |-> ##PER CONV_DONE; endproperty
    a_period: assert property (p_period) else $error("next channel late or early");
    property p_dir; CONV_DONE && cfg_q[1:0] == MODE_DIRECTED |-> SEQ_DONE; endproperty
    a_dir: assert property (p_dir) else $error("directed result lacks sequence end");
    property p_mode2; CONV_DONE && !SEQ_DONE && cfg_q[1:0] == MODE_CH0_TO_1 |-> ##PER SEQ_DONE;
    endproperty
    a_mode2: assert property (p_mode2) else $error("two-channel sequence wrong");
    property p_restart;
        SEQ_DONE && cfg_q[1:0] == MODE_CH0_TO_7 |-> ##[PER:PER1] (CONV_DONE && !SEQ_DONE);
    endproperty
    a_restart: assert property (p_restart) else $error("sequence did not restart");
endmodule
bind vscore_top vscore_top_props #(.CONV_CYC(CONV_CYC)) u_props (.CLOCK(CLOCK), .SRST(SRST),
    .SENSOR_RESET(SENSOR_RESET), .CFG_SHIFT(CFG_SHIFT), .CFG_DATA(CFG_DATA),
    .CONV_DONE(CONV_DONE), .SEQ_DONE(SEQ_DONE), .DATA_OUT(DATA_OUT));
